// file: common/hbg_pkg.sv
package hbg_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_PHASES = 3;
   localparam int NUM_FETS = 2 * NUM_PHASES;
   localparam int DT_W = 7;
   localparam int TMR_W = 12;
   localparam int SYNC_W = 22;

   // ----------------------------------------------------------------
   // Timing, in ns, and derived cycle counts at the reference clock
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int DEAD_MIN_NS = 50;
   localparam int DEAD_MAX_NS = 500;
   localparam int FAULT_DELAY_NS = 200;
   localparam int STARTUP_NS = 10000;
   localparam int QUICK_RESET_NS = 10000;
   localparam logic [DT_W-1:0] DEAD_MIN_CYC =
      DT_W'((DEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [DT_W-1:0] DEAD_MAX_CYC = DT_W'(DEAD_MAX_NS / CLK_PERIOD_NS);
   localparam int FAULT_DELAY_CYC = FAULT_DELAY_NS / CLK_PERIOD_NS;
   localparam logic [TMR_W-1:0] STARTUP_CYC =
      TMR_W'((STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] QUICK_RESET_CYC = TMR_W'(QUICK_RESET_NS / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] TMR_ONE = 12'h001;

   // ----------------------------------------------------------------
   // Enable sequencing states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_OFF,
      ST_START,
      ST_RUN,
      ST_LOW
   } hbg_state_t;
endpackage : hbg_pkg

// file: hdl/hbg_phase.sv
`timescale 1ns/1ns
module hbg_phase import hbg_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_enable,
   input wire logic i_want_high,
   input wire logic i_want_low,
   input wire logic [DT_W-1:0] i_dead_cyc,
   output logic o_high_gate,
   output logic o_low_gate
);
   logic gh_q, gh_d, gl_q, gl_d;
   logic [DT_W-1:0] cnt_q, cnt_d;
   logic last_high_q, last_high_d;
   wire fell_any = (gh_q & ~gh_d) | (gl_q & ~gl_d);
   wire dead_done = (cnt_q >= i_dead_cyc);

   // ----------------------------------------------------------------
   // Gate decisions
   // ----------------------------------------------------------------
   // Turn-on waits until the opposite gate is off and, unless this gate was the last to fall, the floor has run
   wire rise_hi_ok = ~gl_q & (dead_done | last_high_q);
   wire rise_lo_ok = ~gh_q & (dead_done | ~last_high_q);
   // Wants are exclusive, so both gates never rise together
   assign gh_d = i_enable & i_want_high & ~i_want_low & (gh_q | rise_hi_ok);
   assign gl_d = i_enable & i_want_low & ~i_want_high & (gl_q | rise_lo_ok);
   assign cnt_d = fell_any ? '0 : (dead_done ? cnt_q : cnt_q + DT_W'(1'b1));
   assign last_high_d = (gh_q & ~gh_d) ? 1'b1 : ((gl_q & ~gl_d) ? 1'b0 : last_high_q);

   // Gate and dead-time registers
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         gh_q <= 1'b0;
         gl_q <= 1'b0;
         cnt_q <= DEAD_MAX_CYC;
         last_high_q <= 1'b0;
      end else begin
         gh_q <= gh_d;
         gl_q <= gl_d;
         cnt_q <= cnt_d;
         last_high_q <= last_high_d;
      end
   end

   assign o_high_gate = gh_q;
   assign o_low_gate = gl_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_no_overlap: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !(gh_q && gl_q)) else $error("both gates of one phase high");
   chk_hi_after_lo: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $rose(gh_q) |-> !$past(gl_q)) else $error("high gate rose while low gate on");
   chk_dead_floor: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $fell(gl_q) |=> !gh_q [*2]) else $error("high gate rose inside dead time");
   chk_no_extra: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_enable && i_want_high && !i_want_low && !gl_q && dead_done) |=> gh_q)
      else $error("extra delay added after dead time expired");
   chk_off_when_dis: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !i_enable |=> (!gh_q && !gl_q)) else $error("gate on while disabled");
endmodule : hbg_phase

// file: hdl/hbg_ctrl.sv
`timescale 1ns/1ns
module hbg_ctrl import hbg_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_gate_enable,
   input wire logic [NUM_PHASES-1:0] i_high_side_pwm_in,
   input wire logic [NUM_PHASES-1:0] i_low_side_pwm_in,
   input wire logic i_pwm_mode_3,
   input wire logic [DT_W-1:0] i_dead_time_set_pin,
   input wire logic [NUM_FETS-1:0] i_fet_overcurrent,
   input wire logic i_supply_fault,
   input wire logic i_overtemp_warn,
   input wire logic i_fault_flag_pin_low_i,
   input wire logic i_overcurrent_warning_pin_low_i,
   output logic [NUM_PHASES-1:0] o_high_side_gate_out,
   output logic [NUM_PHASES-1:0] o_low_side_gate_out,
   output logic o_fault_flag_pin_low_o,
   output logic o_fault_flag_pin_low_oe,
   output logic o_overcurrent_warning_pin_low_o,
   output logic o_overcurrent_warning_pin_low_oe,
   output logic [NUM_FETS-1:0] o_oc_status,
   output logic o_supply_fault_status,
   output logic o_overtemp_status,
   output logic o_ready
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] sync1_q, sync2_q;

   // Two flip-flops on every pin input except i_pwm_mode_3 and the pin readbacks
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {i_gate_enable, i_high_side_pwm_in, i_low_side_pwm_in,
                     i_dead_time_set_pin, i_fet_overcurrent, i_supply_fault,
                     i_overtemp_warn};
         sync2_q <= sync1_q;
      end
   end

   wire en_s;
   wire sup_s;
   wire ot_s;
   wire [NUM_PHASES-1:0] inh_s;
   wire [NUM_PHASES-1:0] inl_s;
   wire [DT_W-1:0] dtc_s;
   wire [NUM_FETS-1:0] oc_s;

   // Unpack the synchronised pins in the order they were packed
   assign {en_s, inh_s, inl_s, dtc_s, oc_s, sup_s, ot_s} = sync2_q;

   // Dead time clamped to its legal range
   wire [DT_W-1:0] dead_cyc = (dtc_s < DEAD_MIN_CYC) ? DEAD_MIN_CYC :
                              ((dtc_s > DEAD_MAX_CYC) ? DEAD_MAX_CYC : dtc_s);

   // ----------------------------------------------------------------
   // PWM mode decode
   // ----------------------------------------------------------------
   // Returns {want_high, want_low} for one phase
   function automatic logic [1:0] pwm_decode(input logic mode3, input logic inh,
                                             input logic inl);
      logic [1:0] r;
      r = mode3 ? {inh, ~inh} : {inh & ~inl, inl & ~inh};
      return r;
   endfunction : pwm_decode

   // ----------------------------------------------------------------
   // Enable sequencing
   // ----------------------------------------------------------------
   hbg_state_t state_q, state_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   logic ready_q;

   wire start_done = (tmr_q == STARTUP_CYC - TMR_ONE);
   wire quick_over = (tmr_q == QUICK_RESET_CYC - TMR_ONE);

   // Next state: start-up wait, run, and low-pulse measurement
   always_comb begin
      state_d = state_q;
      tmr_d = tmr_q + TMR_ONE;
      case (state_q)
         ST_OFF: begin
            tmr_d = '0;
            if (en_s) begin
               state_d = ST_START;
            end
         end
         ST_START: begin
            if (!en_s) begin
               state_d = ST_OFF;
               tmr_d = '0;
            end else if (start_done) begin
               state_d = ST_RUN;
               tmr_d = '0;
            end
         end
         ST_RUN: begin
            tmr_d = '0;
            if (!en_s) begin
               state_d = ST_LOW;
            end
         end
         ST_LOW: begin
            if (en_s) begin
               state_d = ST_RUN;
               tmr_d = '0;
            end else if (quick_over) begin
               state_d = ST_OFF;
               tmr_d = '0;
            end
         end
         default: begin
            state_d = ST_OFF;
            tmr_d = '0;
         end
      endcase
   end

   // State and timer registers
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= ST_OFF;
         tmr_q <= '0;
         ready_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
         ready_q <= (state_d == ST_RUN);
      end
   end

   // ----------------------------------------------------------------
   // Fault capture
   // ----------------------------------------------------------------
   logic [NUM_FETS-1:0] oc_q;
   logic sup_q, ot_q, fault_pin_q, warn_pin_q;
   logic [NUM_PHASES-1:0] gh, gl;
   logic [NUM_FETS-1:0] fet_on;

   // Faults clear while enable is low; a new event wins over the clear
   wire clear_faults = (state_q == ST_LOW) || (state_q == ST_OFF);
   wire [NUM_FETS-1:0] oc_set = oc_s & fet_on;
   wire [NUM_FETS-1:0] oc_d = oc_set | (clear_faults ? '0 : oc_q);
   wire sup_d = sup_s | (~clear_faults & sup_q);
   wire ot_d = ot_s | (~clear_faults & ot_q);
   wire shut_now = (|oc_q) | sup_q;
   wire drive_en = (state_q == ST_RUN) & ~shut_now;

   // Latched status and open-drain pin enables
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         oc_q <= '0;
         sup_q <= 1'b0;
         ot_q <= 1'b0;
         fault_pin_q <= 1'b0;
         warn_pin_q <= 1'b0;
      end else begin
         oc_q <= oc_d;
         sup_q <= sup_d;
         ot_q <= ot_d;
         fault_pin_q <= (|oc_d) | sup_d;
         warn_pin_q <= (|oc_d) | ot_d;
      end
   end

   // ----------------------------------------------------------------
   // Half-bridge drivers
   // ----------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < NUM_PHASES; p++) begin : g_phase
         wire [1:0] want = pwm_decode(i_pwm_mode_3, inh_s[p], inl_s[p]);
         assign fet_on[2*p] = gh[p];
         assign fet_on[2*p+1] = gl[p];
         hbg_phase u_phase (
            .i_ref_clk(i_ref_clk),
            .i_rstn(i_rstn),
            .i_enable(drive_en),
            .i_want_high(want[1]),
            .i_want_low(want[0]),
            .i_dead_cyc(dead_cyc),
            .o_high_gate(gh[p]),
            .o_low_gate(gl[p])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_high_side_gate_out = gh;
   assign o_low_side_gate_out = gl;
   assign o_fault_flag_pin_low_o = 1'b0; // Open drain only pulls low
   assign o_fault_flag_pin_low_oe = fault_pin_q;
   assign o_overcurrent_warning_pin_low_o = 1'b0;
   assign o_overcurrent_warning_pin_low_oe = warn_pin_q;
   assign o_oc_status = oc_q;
   assign o_supply_fault_status = sup_q;
   assign o_overtemp_status = ot_q;
   assign o_ready = ready_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   localparam int LIMIT_CYC = 50;

   chk_gates_low: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $rose(sup_s) |-> ##[1:LIMIT_CYC] (gh == '0 && gl == '0))
      else $error("gates not low after error event");
   chk_fault_pin: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $rose(sup_s) |-> ##[1:LIMIT_CYC] o_fault_flag_pin_low_oe)
      else $error("fault pin late after error event");
   chk_warn_pin: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (|oc_q) |-> (o_overcurrent_warning_pin_low_oe && o_fault_flag_pin_low_oe))
      else $error("overcurrent not on both pins");
   chk_oc_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      ((|oc_q) && !clear_faults) |=> ((oc_q & $past(oc_q)) == $past(oc_q)))
      else $error("overcurrent status lost");
   chk_startup_wait: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (state_q == ST_START && state_d == ST_RUN) |-> (tmr_q == STARTUP_CYC - TMR_ONE))
      else $error("run entered before start-up time");
   chk_quick_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (state_q == ST_LOW && en_s && oc_s == '0 && !sup_s) |=> (state_q == ST_RUN && !sup_q))
      else $error("quick reset did not restore run");
   chk_shutdown_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      shut_now |=> ##1 (gh == '0 && gl == '0)) else $error("gate on during shutdown");
   chk_mode3_comp: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_pwm_mode_3 && drive_en) |-> (g_phase[0].want[1] != g_phase[0].want[0]))
      else $error("three-input mode not complementary");
endmodule : hbg_ctrl

// file: tb/hbg_host.sv
`timescale 1ns/1ns
module hbg_host import hbg_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic i_ready,
   input wire logic [NUM_PHASES-1:0] i_cmd_hi,
   input wire logic [NUM_PHASES-1:0] i_cmd_lo,
   output logic [NUM_PHASES-1:0] o_high_side_pwm_in,
   output logic [NUM_PHASES-1:0] o_low_side_pwm_in
);
   // Pins idle low from time zero
   initial begin
      o_high_side_pwm_in = '0;
      o_low_side_pwm_in = '0;
   end
   // Commands reach the pins on the falling edge, only once the device is ready
   always @(negedge i_ref_clk) begin
      o_high_side_pwm_in <= i_ready ? i_cmd_hi : '0;
      o_low_side_pwm_in <= i_ready ? i_cmd_lo : '0;
   end
endmodule : hbg_host

// file: tb/half_bridge_gate_control_test.sv
`timescale 1ns/1ns
module half_bridge_gate_control_test;
   import hbg_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic en = 1'b0;
   logic mode3 = 1'b0;
   logic [DT_W-1:0] dead = 7'h14;
   logic [NUM_FETS-1:0] oc = '0;
   logic sup = 1'b0;
   logic otw = 1'b0;
   logic [NUM_PHASES-1:0] cmd_hi = '0;
   logic [NUM_PHASES-1:0] cmd_lo = '0;
   logic [NUM_PHASES-1:0] inh, inl, gh, gl;
   logic [NUM_FETS-1:0] oc_st;
   logic fo, fo_oe, wo, wo_oe, sup_st, ot_st, rdy;
   int errors = 0;
   int tests_run = 0;
   always #2 ref_clk = ~ref_clk;
   hbg_host host (.i_ref_clk(ref_clk), .i_ready(rdy), .i_cmd_hi(cmd_hi), .i_cmd_lo(cmd_lo),
      .o_high_side_pwm_in(inh), .o_low_side_pwm_in(inl));
   hbg_ctrl uut (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_gate_enable(en),
      .i_high_side_pwm_in(inh), .i_low_side_pwm_in(inl), .i_pwm_mode_3(mode3),
      .i_dead_time_set_pin(dead), .i_fet_overcurrent(oc), .i_supply_fault(sup),
      .i_overtemp_warn(otw), .i_fault_flag_pin_low_i(~fo_oe),
      .i_overcurrent_warning_pin_low_i(~wo_oe), .o_high_side_gate_out(gh),
      .o_low_side_gate_out(gl), .o_fault_flag_pin_low_o(fo), .o_fault_flag_pin_low_oe(fo_oe),
      .o_overcurrent_warning_pin_low_o(wo), .o_overcurrent_warning_pin_low_oe(wo_oe),
      .o_oc_status(oc_st), .o_supply_fault_status(sup_st), .o_overtemp_status(ot_st),
      .o_ready(rdy));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_rng(input int n, input int lo, input int hi);
      tests_run++;
      if (n < lo || n > hi) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h..%h", $time, n, lo, hi);
      end
   endtask : chk_rng
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   // Counts cycles until ready, giving up after the bound
   task automatic wait_rdy(input int lim, output int n);
      for (n = 0; rdy !== 1'b1; n++) begin
         if (n >= lim) begin
            errors++;
            give_verdict;
         end
         @(negedge ref_clk);
      end
   endtask : wait_rdy
   // Switches phase commands with a host gap, returns cycles from gate off to other gate on
   task automatic gap(input logic to_lo, input int sep, output int n);
      int t;
      int tf;
      tf = -1;
      n = -1;
      if (to_lo) cmd_hi <= '0;
      else cmd_lo <= '0;
      for (t = 0; t < 700 && n < 0; t++) begin
         if (t == sep) begin
            if (to_lo) cmd_lo <= '1;
            else cmd_hi <= '1;
         end
         @(negedge ref_clk);
         if (gh[0] & gl[0]) chk(8'h01, 8'h00);
         if (tf < 0 && (to_lo ? gh[0] : gl[0]) === 1'b0) tf = t;
         if (tf >= 0 && (to_lo ? gl[0] : gh[0]) === 1'b1) n = t - tf;
      end
   endtask : gap
   task automatic qreset;
      int n;
      en <= 1'b0;
      cyc(10);
      en <= 1'b1;
      wait_rdy(20, n);
      chk_rng(n, 1, 12);
      chk({sup_st, ot_st, fo_oe, wo_oe}, 8'h00);
   endtask : qreset
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_startup;
      int n;
      chk({gh, gl, fo_oe, wo_oe}, 8'h00);
      en <= 1'b1;
      wait_rdy(3000, n);
      chk_rng(n, 2500, 2506);
   endtask : t_startup
   task automatic t_decode;
      for (int c = 0; c < 4; c++) begin
         cmd_hi <= {3{c[0]}};
         cmd_lo <= {3{c[1]}};
         cyc(200);
         chk({gh, gl}, {(c == 1) ? 3'h7 : 3'h0, (c == 2) ? 3'h7 : 3'h0});
      end
      mode3 <= 1'b1;
      for (int h = 0; h < 2; h++) begin
         cmd_hi <= {3{h[0]}};
         cmd_lo <= {3{h[0]}};
         cyc(200);
         chk({gh, gl}, {h[0] ? 3'h7 : 3'h0, h[0] ? 3'h0 : 3'h7});
      end
      mode3 <= 1'b0;
   endtask : t_decode
   task automatic t_dead;
      logic [DT_W-1:0] vals [3] = '{7'h05, 7'h14, 7'h7F};
      int n;
      int e;
      foreach (vals[i]) begin
         e = (vals[i] < DEAD_MIN_CYC) ? DEAD_MIN_CYC : (vals[i] > DEAD_MAX_CYC) ?
            DEAD_MAX_CYC : vals[i];
         dead <= vals[i];
         cmd_hi <= '1;
         cmd_lo <= '0;
         cyc(300);
         gap(1'b1, 0, n);
         chk_rng(n, e, e + 2);
         gap(1'b0, 0, n);
         chk_rng(n, e, e + 2);
         gap(1'b1, e + 30, n);
         chk_rng(n, e + 30, e + 32);
      end
   endtask : t_dead
   task automatic t_fault;
      int n;
      cmd_hi <= '1;
      cmd_lo <= '0;
      cyc(300);
      sup <= 1'b1;
      for (n = 0; n < 60 && ({gh, gl} !== 6'h00 || fo_oe !== 1'b1); n++) cyc(1);
      chk_rng(n, 0, FAULT_DELAY_CYC);
      chk({sup_st, fo_oe}, 8'h03);
      chk({fo, wo}, 8'h00);
      sup <= 1'b0;
      cyc(30);
      chk({gh, gl}, 8'h00);
      qreset;
      cyc(60);
      chk({gh, gl}, 8'h38);
   endtask : t_fault
   task automatic t_oc;
      oc <= 6'h04;
      cyc(5);
      oc <= 6'h00;
      cyc(10);
      chk(oc_st, 8'h04);
      chk({fo_oe, gh, gl}, 8'h40);
      qreset;
      cyc(60);
      otw <= 1'b1;
      cyc(8);
      chk({wo_oe, ot_st, fo_oe}, 8'h06);
      chk({gh, gl}, 8'h38);
      otw <= 1'b0;
      qreset;
   endtask : t_oc
   // Main sequence
   initial begin
      repeat (12) @(negedge ref_clk);
      rstn <= 1'b1;
      t_startup;
      t_decode;
      t_dead;
      t_fault;
      t_oc;
      give_verdict;
   end
endmodule : half_bridge_gate_control_test
